// ---- core/led_indicator_control.sv ----
// second status indicator controller with blink timing and activity grading
// Contract
// - The lit phase of a blink lasts the on-time field times 4 ms.
// - The dark phase of a blink lasts the off-time field times 4 ms.
// - Both blink time fields come out of reset at 0x36, and software should keep them above 3.
// - With mode 0 each blink cycle opens with the dark phase and then the lit phase.
// - With mode 1 each blink cycle opens with the lit phase and then the dark phase.
// - With both time fields at zero the selected activity signal drives the indicator live.
// - A link-and-traffic source lights the indicator on an idle link and darkens it on link loss or traffic.
// - A traffic-only source keeps the indicator dark when idle and lights it on traffic.
// - Clearing the enable bit forces the indicator dark; it resets set.
// - The gate bit ties the amplitude and role indications to link state when set.
// - Mode 0 blinks at the programmed times whenever traffic is present, and for link-and-traffic sources only while the link is up.
// - Mode 1 grades traffic in 10% steps, lengthening the dark and shortening the lit phase as traffic rises.
// - Mode 1 re-measures the traffic level once per window of 640 ms to 1.5 s.
// - Steady, blink and mismatch selections are never gated by link state.
// - Level and role selections bypass blinking and show the chosen signal steadily.
`timescale 1ns/10ps
module led_indicator_control #(
  parameter int UNIT_CYCLES = led_indicator_pkg::UNIT_CYCLES,
  parameter int WINDOW_UNITS = led_indicator_pkg::WINDOW_UNITS
) (
  // clock, reset, freeze
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  // management register access
  input wire logic [15:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [15:0] reg_wdata_in,
  output logic [15:0] reg_rdata_out,
  output logic reg_rvalid_out,
  // port status from the core
  input wire logic link_up_in,
  input wire logic send_traffic_in,
  input wire logic receive_traffic_in,
  input wire logic high_amplitude_indication_in,
  input wire logic low_amplitude_indication_in,
  input wire logic leader_role_in,
  input wire logic follower_role_in,
  input wire logic mismatched_link_setup_in,
  // indicator
  output logic led_out
);

  localparam int PRE_W = $clog2(UNIT_CYCLES);
  localparam int LEN_W = led_indicator_pkg::LEN_W;
  localparam int GRADE_W = led_indicator_pkg::GRADE_W;
  localparam int WIN_W = led_indicator_pkg::WIN_W;
  localparam int PROD_W = 2 * LEN_W;

  // ---- registers
  logic [15:0] times_r, times_nxt, ctrl_r, ctrl_nxt, rdata_r, rdata_nxt;
  logic rvalid_r, rvalid_nxt;

  always_comb begin
    times_nxt = times_r;
    ctrl_nxt = ctrl_r;
    rdata_nxt = rdata_r;
    rvalid_nxt = reg_rd_in;
    if (reg_wr_in && reg_addr_in == led_indicator_pkg::TIMES_ADDR) begin
      times_nxt = reg_wdata_in;
    end
    if (reg_wr_in && reg_addr_in == led_indicator_pkg::CTRL_ADDR) begin
      ctrl_nxt = reg_wdata_in;
    end
    if (reg_rd_in) begin
      unique case (reg_addr_in)
        led_indicator_pkg::TIMES_ADDR: rdata_nxt = times_r;
        led_indicator_pkg::CTRL_ADDR: rdata_nxt = ctrl_r;
        default: rdata_nxt = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      times_r <= led_indicator_pkg::TIMES_RESET;
      ctrl_r <= led_indicator_pkg::CTRL_RESET;
      rdata_r <= 16'h0000;
      rvalid_r <= 1'b0;
    end else if (ce_in) begin
      times_r <= times_nxt;
      ctrl_r <= ctrl_nxt;
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  assign reg_rdata_out = rdata_r;
  assign reg_rvalid_out = rvalid_r;

  // ---- field decode
  logic [7:0] on_time_count, off_time_count;
  logic [4:0] indicator_source_select;
  logic indicator_enable, gate_with_link_state, indicator_mode_select;

  assign on_time_count = times_r[led_indicator_pkg::ON_MSB:led_indicator_pkg::ON_LSB];
  assign off_time_count = times_r[led_indicator_pkg::OFF_MSB:led_indicator_pkg::OFF_LSB];
  assign indicator_enable = ctrl_r[led_indicator_pkg::EN_BIT];
  assign gate_with_link_state = ctrl_r[led_indicator_pkg::QUAL_BIT];
  assign indicator_mode_select = ctrl_r[led_indicator_pkg::MODE_BIT];
  assign indicator_source_select = ctrl_r[led_indicator_pkg::FUNC_MSB:led_indicator_pkg::FUNC_LSB];

  // ---- 4 ms tick
  logic [PRE_W-1:0] pre_r, pre_nxt;
  logic tick;

  assign tick = (pre_r == PRE_W'(UNIT_CYCLES - 1));

  always_comb begin
    pre_nxt = tick ? '0 : pre_r + PRE_W'(1);
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      pre_r <= '0;
    end else if (ce_in) begin
      pre_r <= pre_nxt;
    end
  end

  // ---- source selection
  logic act_sel, link_traffic_fn, traffic_fn, level_role_fn;

  always_comb begin
    act_sel = 1'b0;
    unique case (indicator_source_select)
      led_indicator_pkg::LINK_ANY_TRAFFIC_FN, led_indicator_pkg::ANY_TRAFFIC_FN:
        act_sel = send_traffic_in | receive_traffic_in;
      led_indicator_pkg::LINK_SEND_TRAFFIC_FN, led_indicator_pkg::SEND_TRAFFIC_FN:
        act_sel = send_traffic_in;
      led_indicator_pkg::LINK_RECEIVE_TRAFFIC_FN, led_indicator_pkg::RECEIVE_TRAFFIC_FN:
        act_sel = receive_traffic_in;
      default: act_sel = 1'b0;
    endcase
  end

  assign link_traffic_fn = (indicator_source_select <= led_indicator_pkg::LINK_RECEIVE_TRAFFIC_FN);
  assign traffic_fn = (indicator_source_select >= led_indicator_pkg::ANY_TRAFFIC_FN) &&
                      (indicator_source_select <= led_indicator_pkg::RECEIVE_TRAFFIC_FN);
  assign level_role_fn = (indicator_source_select >= led_indicator_pkg::HIGH_AMPLITUDE_FN) &&
                         (indicator_source_select <= led_indicator_pkg::FOLLOWER_FN);

  // ---- traffic grading over one window
  logic [WIN_W-1:0] win_r, win_nxt, units_r, units_nxt, units_total;
  logic unit_act_r, unit_act_nxt;
  logic [GRADE_W-1:0] grade_r, grade_nxt;

  assign units_total = units_r + WIN_W'(unit_act_r | act_sel);

  always_comb begin
    win_nxt = win_r;
    units_nxt = units_r;
    grade_nxt = grade_r;
    unit_act_nxt = unit_act_r | act_sel;
    if (tick) begin
      unit_act_nxt = 1'b0;
      if (win_r == WIN_W'(WINDOW_UNITS - 1)) begin
        win_nxt = '0;
        units_nxt = '0;
        // one grade per 10% of the window that saw traffic
        grade_nxt = GRADE_W'(units_total / WIN_W'(led_indicator_pkg::UNITS_PER_GRADE));
        if (grade_nxt > led_indicator_pkg::GRADE_STEPS) begin
          grade_nxt = led_indicator_pkg::GRADE_STEPS;
        end
      end else begin
        win_nxt = win_r + WIN_W'(1);
        units_nxt = units_total;
      end
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      win_r <= '0;
      units_r <= '0;
      unit_act_r <= 1'b0;
      grade_r <= '0;
    end else if (ce_in) begin
      win_r <= win_nxt;
      units_r <= units_nxt;
      unit_act_r <= unit_act_nxt;
      grade_r <= grade_nxt;
    end
  end

  // ---- blink lengths: graded mode trades lit time for dark time
  logic [LEN_W-1:0] on_len, off_len, on_scaled, off_scaled;

  always_comb begin
    on_scaled = LEN_W'(PROD_W'(on_time_count) * (PROD_W'(led_indicator_pkg::GRADE_STEPS) - PROD_W'(grade_r)) /
                       PROD_W'(led_indicator_pkg::GRADE_STEPS));
    off_scaled = LEN_W'(PROD_W'(off_time_count) * (PROD_W'(led_indicator_pkg::GRADE_STEPS) + PROD_W'(grade_r)) /
                        PROD_W'(led_indicator_pkg::GRADE_STEPS));
    on_len = indicator_mode_select ? on_scaled : LEN_W'(on_time_count);
    off_len = indicator_mode_select ? off_scaled : LEN_W'(off_time_count);
  end

  // ---- blink run control; a started cycle completes even if traffic stops
  logic busy_r, busy_nxt, pending, run, phase_on, cycle_done;

  always_comb begin
    busy_nxt = busy_r;
    // a blink that is no longer allowed to run must not resume later from stale state
    if (cycle_done || !run) begin
      busy_nxt = 1'b0;
    end
    if (act_sel) begin
      busy_nxt = 1'b1;
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      busy_r <= 1'b0;
    end else if (ce_in) begin
      busy_r <= busy_nxt;
    end
  end

  assign pending = indicator_mode_select ? (grade_r != '0) | busy_r : act_sel | busy_r;
  assign run = (link_traffic_fn & link_up_in & pending) | (traffic_fn & pending) |
               (indicator_source_select == led_indicator_pkg::FREE_BLINK_FN);

  blink_phase_engine #(
    .LEN_W(LEN_W)
  ) u_blink (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .tick_in(tick),
    .run_in(run),
    .start_on_in(indicator_mode_select),
    .on_len_in(on_len),
    .off_len_in(off_len),
    .phase_on_out(phase_on),
    .cycle_done_out(cycle_done)
  );

  // ---- indicator output
  logic live, led_r, led_nxt, level_role_sig;

  assign live = (on_time_count == 8'h00) && (off_time_count == 8'h00);

  always_comb begin
    level_role_sig = 1'b0;
    unique case (indicator_source_select)
      led_indicator_pkg::HIGH_AMPLITUDE_FN: level_role_sig = high_amplitude_indication_in;
      led_indicator_pkg::LOW_AMPLITUDE_FN: level_role_sig = low_amplitude_indication_in;
      led_indicator_pkg::LEADER_FN: level_role_sig = leader_role_in;
      led_indicator_pkg::FOLLOWER_FN: level_role_sig = follower_role_in;
      default: level_role_sig = 1'b0;
    endcase
  end

  always_comb begin
    led_nxt = 1'b0;
    if (!indicator_enable) begin
      led_nxt = 1'b0;
    end else if (link_traffic_fn) begin
      if (live) begin
        led_nxt = link_up_in & ~act_sel;
      end else begin
        led_nxt = link_up_in & (run ? phase_on : 1'b1);
      end
    end else if (traffic_fn) begin
      led_nxt = live ? act_sel : (run & phase_on);
    end else if (level_role_fn) begin
      led_nxt = level_role_sig & (~gate_with_link_state | link_up_in);
    end else begin
      unique case (indicator_source_select)
        led_indicator_pkg::LINK_ALONE_FN: led_nxt = link_up_in;
        led_indicator_pkg::STEADY_ON_FN: led_nxt = 1'b1;
        led_indicator_pkg::FREE_BLINK_FN: led_nxt = phase_on;
        led_indicator_pkg::MISMATCHED_LINK_SETUP_FN: led_nxt = mismatched_link_setup_in;
        default: led_nxt = 1'b0;
      endcase
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      led_r <= 1'b0;
    end else if (ce_in) begin
      led_r <= led_nxt;
    end
  end

  assign led_out = led_r;

  // ---- checks
  times_reset_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    $past(rst_in) |-> (times_r == led_indicator_pkg::TIMES_RESET && ctrl_r == led_indicator_pkg::CTRL_RESET))
    else $error("register reset value wrong");
  disabled_dark_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (ce_in && !indicator_enable) |=> !led_out)
    else $error("disabled indicator lit");

  live_link_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (ce_in && indicator_enable && live && link_traffic_fn) |=> (led_out == $past(link_up_in & ~act_sel)))
    else $error("live link traffic view wrong");
  link_loss_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (ce_in && link_traffic_fn && !link_up_in) |=> !led_out)
    else $error("indicator lit without link");

  idle_dark_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (ce_in && traffic_fn && !run && !live) |=> !led_out)
    else $error("traffic indicator lit while idle");
  gated_level_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (ce_in && level_role_fn && gate_with_link_state && !link_up_in) |=> !led_out)
    else $error("gated level shown without link");

  steady_status_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (ce_in && indicator_enable && level_role_fn && !gate_with_link_state) |=> (led_out == $past(level_role_sig)))
    else $error("status indication not steady");

  never_gated_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (ce_in && indicator_enable && indicator_source_select == led_indicator_pkg::STEADY_ON_FN) |=> led_out)
    else $error("steady on not lit");

  grade_range_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    grade_r <= led_indicator_pkg::GRADE_STEPS)
    else $error("traffic grade out of range");
  window_len_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (ce_in && !(tick && win_r == WIN_W'(WINDOW_UNITS - 1))) |=> $stable(grade_r))
    else $error("traffic grade changed inside a window");

  blink_seen_c: cover property (@(posedge core_clk_in) disable iff (rst_in)
    run && $rose(phase_on));
  graded_c: cover property (@(posedge core_clk_in) disable iff (rst_in)
    indicator_mode_select && grade_r != '0);
  live_c: cover property (@(posedge core_clk_in) disable iff (rst_in)
    live && traffic_fn && led_out);
  gated_c: cover property (@(posedge core_clk_in) disable iff (rst_in)
    level_role_fn && gate_with_link_state && level_role_sig && !link_up_in);

endmodule // led_indicator_control

// ---- core/led_indicator_pkg.sv ----
// shared constants and types for the second status indicator controller
package led_indicator_pkg;

  // register map in the management space
  localparam logic [15:0] TIMES_ADDR = 16'h8C81;
  localparam logic [15:0] CTRL_ADDR = 16'h8C82;
  localparam logic [15:0] TIMES_RESET = 16'h3636;
  localparam logic [15:0] CTRL_RESET = 16'h8E80;

  // field layout
  localparam int FIELD_W = 8;
  localparam int ON_MSB = 15;
  localparam int ON_LSB = 8;
  localparam int OFF_MSB = 7;
  localparam int OFF_LSB = 0;
  localparam int EN_BIT = 15;
  localparam int QUAL_BIT = 14;
  localparam int MODE_BIT = 13;
  localparam int FUNC_MSB = 12;
  localparam int FUNC_LSB = 8;
  localparam int FUNC_W = 5;

  // source selections
  localparam logic [4:0] LINK_ANY_TRAFFIC_FN = 5'h00;
  localparam logic [4:0] LINK_SEND_TRAFFIC_FN = 5'h01;
  localparam logic [4:0] LINK_RECEIVE_TRAFFIC_FN = 5'h02;
  localparam logic [4:0] LINK_ALONE_FN = 5'h03;
  localparam logic [4:0] ANY_TRAFFIC_FN = 5'h04;
  localparam logic [4:0] SEND_TRAFFIC_FN = 5'h05;
  localparam logic [4:0] RECEIVE_TRAFFIC_FN = 5'h06;
  localparam logic [4:0] STEADY_ON_FN = 5'h0D;
  localparam logic [4:0] STEADY_OFF_FN = 5'h0E;
  localparam logic [4:0] FREE_BLINK_FN = 5'h0F;
  localparam logic [4:0] HIGH_AMPLITUDE_FN = 5'h10;
  localparam logic [4:0] LOW_AMPLITUDE_FN = 5'h11;
  localparam logic [4:0] LEADER_FN = 5'h12;
  localparam logic [4:0] FOLLOWER_FN = 5'h13;
  localparam logic [4:0] MISMATCHED_LINK_SETUP_FN = 5'h14;

  // timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int UNIT_TIME_MS = 4;
  localparam int UNIT_CYCLES = (UNIT_TIME_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WINDOW_TIME_MS = 1000;
  localparam int WINDOW_UNITS = WINDOW_TIME_MS / UNIT_TIME_MS;
  localparam int WIN_W = 8;
  localparam int LEN_W = 12;
  localparam int GRADE_W = 4;
  localparam logic [3:0] GRADE_STEPS = 4'hA;
  localparam int UNITS_PER_GRADE = WINDOW_UNITS / 10;

  typedef enum logic {PH_OFF, PH_ON} blink_phase_t;

endpackage

// ---- core/blink_phase_engine.sv ----
// on/off phase sequencer counted in 4 ms ticks
`timescale 1ns/10ps
module blink_phase_engine #(
  parameter int LEN_W = led_indicator_pkg::LEN_W
) (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  // control
  input wire logic tick_in,
  input wire logic run_in,
  input wire logic start_on_in,
  input wire logic [LEN_W-1:0] on_len_in,
  input wire logic [LEN_W-1:0] off_len_in,
  // status
  output logic phase_on_out,
  output logic cycle_done_out
);

  led_indicator_pkg::blink_phase_t phase_r, phase_nxt, start_ph;
  logic [LEN_W-1:0] cnt_r, cnt_nxt, len_r, len_nxt, on_eff, off_eff;
  logic done_r, done_nxt, run_r, load;

  // a zero-length phase would stall the sequence, so it lasts one tick
  assign on_eff = (on_len_in == '0) ? LEN_W'(1) : on_len_in;
  assign off_eff = (off_len_in == '0) ? LEN_W'(1) : off_len_in;

  // the first running cycle reloads the start phase, since one write can change mode and run together
  assign load = !run_in || !run_r;

  always_comb begin
    start_ph = start_on_in ? led_indicator_pkg::PH_ON : led_indicator_pkg::PH_OFF;
    phase_nxt = phase_r;
    cnt_nxt = cnt_r;
    len_nxt = len_r;
    done_nxt = 1'b0;
    if (load) begin
      phase_nxt = start_ph;
      cnt_nxt = '0;
      len_nxt = start_on_in ? on_eff : off_eff;
    end else if (tick_in) begin
      if (cnt_r + LEN_W'(1) >= len_r) begin
        phase_nxt = (phase_r == led_indicator_pkg::PH_ON) ? led_indicator_pkg::PH_OFF : led_indicator_pkg::PH_ON;
        cnt_nxt = '0;
        // lengths are taken at phase entry, so a grade change never cuts a running phase short
        len_nxt = (phase_r == led_indicator_pkg::PH_ON) ? off_eff : on_eff;
        done_nxt = (phase_nxt == start_ph);
      end else begin
        cnt_nxt = cnt_r + LEN_W'(1);
      end
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      phase_r <= led_indicator_pkg::PH_OFF;
      cnt_r <= '0;
      len_r <= LEN_W'(1);
      done_r <= 1'b0;
      run_r <= 1'b0;
    end else if (ce_in) begin
      phase_r <= phase_nxt;
      cnt_r <= cnt_nxt;
      len_r <= len_nxt;
      done_r <= done_nxt;
      run_r <= run_in;
    end
  end

  assign phase_on_out = run_r ? (phase_r == led_indicator_pkg::PH_ON) : start_on_in;
  assign cycle_done_out = done_r;

  // helper: ticks spent in the current phase, independent of cnt_r
  logic [LEN_W-1:0] seen_r, want_r;
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      seen_r <= '0;
      want_r <= LEN_W'(1);
    end else if (ce_in) begin
      if (load || phase_nxt != phase_r) begin
        seen_r <= '0;
        want_r <= (phase_nxt == led_indicator_pkg::PH_ON) ? on_eff : off_eff;
      end else if (tick_in) begin
        seen_r <= seen_r + LEN_W'(1);
      end
    end
  end

  on_phase_len_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (ce_in && !load && tick_in && phase_r == led_indicator_pkg::PH_ON && phase_nxt == led_indicator_pkg::PH_OFF)
    |-> (seen_r + LEN_W'(1) == want_r))
    else $error("on phase length wrong");

  off_phase_len_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (ce_in && !load && tick_in && phase_r == led_indicator_pkg::PH_OFF && phase_nxt == led_indicator_pkg::PH_ON)
    |-> (seen_r + LEN_W'(1) == want_r))
    else $error("off phase length wrong");

  start_phase_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    (ce_in && !run_in) |=> ((phase_r == led_indicator_pkg::PH_ON) == $past(start_on_in)))
    else $error("blink does not start in the selected phase");

endmodule // blink_phase_engine

// ---- testbench/led_lamp.sv ----
// external indicator lamp that records how long its last lit and dark spans lasted
`timescale 1ns/10ps
module led_lamp (
  // clock and drive
  input wire logic clk_in,
  input wire logic led_in,
  // spans in clock cycles
  output logic [15:0] lit_len_out,
  output logic [15:0] dark_len_out
);
  logic [15:0] run_r;
  logic last_r;
  initial begin
    run_r = 16'h0000;
    last_r = 1'b0;
    lit_len_out = 16'h0000;
    dark_len_out = 16'h0000;
  end
  // a span is closed only when the lamp changes, so a stuck lamp keeps old spans
  always @(posedge clk_in) begin
    if (led_in !== last_r) begin
      if (last_r === 1'b1) lit_len_out <= run_r;
      else dark_len_out <= run_r;
      run_r <= 16'h0001;
    end else begin
      run_r <= run_r + 16'h0001;
    end
    last_r <= led_in;
  end
endmodule // led_lamp

// ---- testbench/testbench.sv ----
// self-checking bench for the second status indicator controller
`timescale 1ns/10ps
module testbench;
  localparam int UC = 4;
  logic core_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic wr = 1'b0;
  logic rd_s = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [15:0] wdata = 16'h0000;
  logic link = 1'b0;
  logic send = 1'b0;
  logic recv = 1'b0;
  logic hi = 1'b0;
  logic lo = 1'b0;
  logic ldr = 1'b0;
  logic fol = 1'b0;
  logic mism = 1'b0;
  logic [15:0] rdata;
  logic rvalid;
  logic led;
  logic [15:0] lit_len;
  logic [15:0] dark_len;
  logic [15:0] d;
  int fails = 0;
  int checked = 0;

  always #12.5 core_clk_in = ~core_clk_in;

  led_indicator_control #(.UNIT_CYCLES(UC)) dut (
    .core_clk_in(core_clk_in), .rst_in(rst_in), .ce_in(1'b1),
    .reg_addr_in(addr), .reg_wr_in(wr), .reg_rd_in(rd_s), .reg_wdata_in(wdata),
    .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
    .link_up_in(link), .send_traffic_in(send), .receive_traffic_in(recv),
    .high_amplitude_indication_in(hi), .low_amplitude_indication_in(lo),
    .leader_role_in(ldr), .follower_role_in(fol), .mismatched_link_setup_in(mism),
    .led_out(led));

  led_lamp lamp (.clk_in(core_clk_in), .led_in(led), .lit_len_out(lit_len), .dark_len_out(dark_len));

  task summarize;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // every task starts and ends just after a rising edge
  task cyc(input int n);
    repeat (n) @(posedge core_clk_in);
    #1;
  endtask

  task wreg(input logic [15:0] a, input logic [15:0] v);
    addr = a;
    wdata = v;
    wr = 1'b1;
    cyc(1);
    wr = 1'b0;
    cyc(1);
  endtask

  task rreg(input logic [15:0] a, output logic [15:0] v);
    addr = a;
    rd_s = 1'b1;
    cyc(1);
    rd_s = 1'b0;
    chk("read valid", 16'h0001, {15'h0000, rvalid});
    v = rdata;
    cyc(1);
  endtask

  // the indicator follows its inputs one edge later; two edges leave margin
  task see(input logic e, input string what);
    cyc(2);
    chk(what, {15'h0000, e}, {15'h0000, led});
  endtask

  function automatic logic [15:0] cw(input logic m, input logic q, input logic [4:0] f);
    return {1'b1, q, m, f, 8'h00};
  endfunction

  task t_reset;
    rreg(led_indicator_pkg::TIMES_ADDR, d);
    chk("times reset", 16'h3636, d);
    rreg(led_indicator_pkg::CTRL_ADDR, d);
    chk("control reset", 16'h8E80, d);
    rreg(16'h8C83, d);
    chk("unmapped read", 16'h0000, d);
    chk("led after reset", 16'h0000, {15'h0000, led});
  endtask

  task t_live;
    wreg(led_indicator_pkg::TIMES_ADDR, 16'h0000);
    wreg(led_indicator_pkg::CTRL_ADDR, cw(1'b0, 1'b0, led_indicator_pkg::LINK_ANY_TRAFFIC_FN));
    link = 1'b1;
    see(1'b1, "link idle");
    recv = 1'b1;
    see(1'b0, "link with traffic");
    link = 1'b0;
    recv = 1'b0;
    see(1'b0, "link lost");
    wreg(led_indicator_pkg::CTRL_ADDR, cw(1'b0, 1'b0, led_indicator_pkg::LINK_SEND_TRAFFIC_FN));
    link = 1'b1;
    recv = 1'b1;
    see(1'b1, "send source ignores receive");
    wreg(led_indicator_pkg::CTRL_ADDR, cw(1'b0, 1'b0, led_indicator_pkg::LINK_RECEIVE_TRAFFIC_FN));
    see(1'b0, "receive source");
    wreg(led_indicator_pkg::CTRL_ADDR, cw(1'b0, 1'b0, led_indicator_pkg::LINK_ALONE_FN));
    see(1'b1, "link alone");
    wreg(led_indicator_pkg::CTRL_ADDR, cw(1'b0, 1'b0, led_indicator_pkg::ANY_TRAFFIC_FN));
    recv = 1'b0;
    see(1'b0, "traffic idle");
    send = 1'b1;
    see(1'b1, "traffic live");
    send = 1'b0;
  endtask

  task t_steady;
    wreg(led_indicator_pkg::CTRL_ADDR, cw(1'b0, 1'b0, led_indicator_pkg::STEADY_ON_FN));
    link = 1'b0;
    see(1'b1, "steady on");
    wreg(led_indicator_pkg::CTRL_ADDR, cw(1'b0, 1'b0, led_indicator_pkg::STEADY_ON_FN) & 16'h7FFF);
    see(1'b0, "disabled");
    for (int k = 0; k < 4; k++) begin
      {hi, lo, ldr, fol} = 4'h8 >> k;
      wreg(led_indicator_pkg::CTRL_ADDR, cw(1'b0, 1'b0, led_indicator_pkg::HIGH_AMPLITUDE_FN + 5'(k)));
      see(1'b1, "status ungated");
      wreg(led_indicator_pkg::CTRL_ADDR, cw(1'b0, 1'b1, led_indicator_pkg::HIGH_AMPLITUDE_FN + 5'(k)));
      see(1'b0, "status gated");
      link = 1'b1;
      see(1'b1, "status with link");
      {hi, lo, ldr, fol} = 4'h0;
      see(1'b0, "status low");
      link = 1'b0;
    end
    mism = 1'b1;
    wreg(led_indicator_pkg::CTRL_ADDR, cw(1'b0, 1'b1, led_indicator_pkg::MISMATCHED_LINK_SETUP_FN));
    see(1'b1, "mismatch ungated");
    mism = 1'b0;
  endtask

  task t_blink;
    wreg(led_indicator_pkg::TIMES_ADDR, 16'h0504);
    wreg(led_indicator_pkg::CTRL_ADDR, cw(1'b0, 1'b0, led_indicator_pkg::ANY_TRAFFIC_FN));
    send = 1'b1;
    see(1'b0, "traffic blink opens dark");
    cyc(200);
    chk("lit span", 16'(5 * UC), lit_len);
    chk("dark span", 16'(4 * UC), dark_len);
    send = 1'b0;
    for (int m = 0; m < 2; m++) begin
      wreg(led_indicator_pkg::CTRL_ADDR, cw(1'b0, 1'b0, led_indicator_pkg::STEADY_OFF_FN));
      cyc(60);
      wreg(led_indicator_pkg::CTRL_ADDR, cw(1'(m), 1'b0, led_indicator_pkg::FREE_BLINK_FN));
      cyc(6);
      chk("free blink first phase", 16'(m), {15'h0000, led});
    end
  endtask

  task t_graded;
    wreg(led_indicator_pkg::TIMES_ADDR, 16'h2828);
    wreg(led_indicator_pkg::CTRL_ADDR, cw(1'b1, 1'b0, led_indicator_pkg::ANY_TRAFFIC_FN));
    send = 1'b1;
    // full traffic over two windows gives the top grade: lit shrinks to one tick
    cyc(3000);
    chk("graded lit span", 16'(UC), lit_len);
    chk("graded dark span", 16'(80 * UC), dark_len);
    send = 1'b0;
  endtask

  initial begin
    repeat (2) @(posedge core_clk_in);
    #1;
    rst_in = 1'b0;
    t_reset;
    t_live;
    t_steady;
    t_blink;
    t_graded;
    summarize;
  end

  // the scenarios need about 3450 cycles
  initial begin
    #(25 * 10000);
    fails++;
    summarize;
  end
endmodule // testbench
